// *** logic/dbah_arbiter.sv ***
/*
 Bus arbiter end: base clock divider, request poll counter, DMA grant,
 processor phase sequencer, transaction timeout and fault report, and the
 processor and memory side of the shared bus handshake.
 Assumes the DMA master and the processor logic run on the same clock.
*/
`timescale 1ns/1ns
module dbah_arbiter (
    input  wire logic                        clk,             // System clock
    input  wire logic                        sys_rst,         // Sync reset, high
    dbah_bus_if.arb                          bus,             // Shared bus
    input  wire logic                        bus_available,   // Processor idle
    input  wire logic [dbah_pkg::ADDR_W-1:0] cpu_addr,        // Processor address
    input  wire logic                        cpu_addr_valid,  // Processor cycle
    input  wire logic                        cpu_write,       // 1 = write
    input  wire logic [dbah_pkg::DATA_W-1:0] cpu_wdata,       // Write data
    input  wire logic                        cpu_data_valid,  // Write data ready
    input  wire logic [dbah_pkg::DATA_W-1:0] mem_rdata,       // Memory read data
    input  wire logic                        mem_read_ready,  // Memory data valid
    output logic                             cpu_data_ack,    // Data strobe seen
    output logic [dbah_pkg::DATA_W-1:0]      cpu_rdata,       // Read data
    output logic [dbah_pkg::ADDR_W-1:0]      mem_addr,        // Latched address
    output logic [dbah_pkg::DATA_W-1:0]      mem_wdata,       // Latched write data
    output logic                             mem_write_en,    // Write pulse
    output logic                             phase1,          // Processor phase 1
    output logic                             phase2,          // Processor phase 2
    output logic                             dma_owner,       // DMA holds bus
    output logic                             transaction_fault // Bus failure
);
    import dbah_pkg::*;

    logic [ACC_W-1:0]    acc_reg, acc_next;
    logic                base_tick;
    logic                poll_half_reg, poll_half_next;
    logic                poll_tick;
    logic [POLL_W-1:0]   poll_reg, poll_next;
    dbah_grant_t         grant_reg, grant_next;
    logic [JC_W-1:0]     jc_reg, jc_next;
    logic [TO_W-1:0]     to_cnt_reg, to_cnt_next;
    logic                timeout_reg, timeout_next;
    logic                fault_reg, fault_next;
    logic                as_prev_reg, ds_prev_reg;
    logic [ADDR_W-1:0]   mem_addr_reg, mem_addr_next;
    logic [DATA_W-1:0]   mem_wdata_reg, mem_wdata_next;
    logic                mem_wr_reg, mem_wr_next;
    logic [DATA_W-1:0]   cpu_rdata_reg, cpu_rdata_next;
    logic                as_n, ds_n;
    logic                cpu_own, cpu_cycle, mem_answer;
    logic                in_txn, wait_hold, counter_clear;

    assign as_n       = bus.addr_valid_strobe_n;
    assign ds_n       = bus.data_valid_strobe_n;
    assign cpu_own    = (grant_reg == DBAH_GR_IDLE);
    assign cpu_cycle  = cpu_own && cpu_addr_valid;
    assign mem_answer = !as_n && bus.bus_write_n && mem_read_ready;
    assign in_txn     = !as_n && ds_n;

    // Base timing: phase accumulator carry gives 14.7456 MHz enables
    always_comb begin
        {base_tick, acc_next} = {1'b0, acc_reg} + {1'b0, BASE_INC};
        poll_half_next = base_tick ? ~poll_half_reg : poll_half_reg;
    end
    assign poll_tick = base_tick && poll_half_reg;

    // Poll counter freezes while a request waits at the current level
    always_comb begin
        poll_next = poll_reg;
        if (poll_tick && cpu_own && bus.dma_request_n) begin
            poll_next = poll_reg + 3'h1;
        end
    end

    // Grant: one character per grant, ended by the master's request release or a timeout
    always_comb begin
        grant_next = grant_reg;
        case (grant_reg)
            DBAH_GR_IDLE: begin
                if (base_tick && !bus.dma_request_n && bus_available && phase1
                    && as_n) begin
                    grant_next = DBAH_GR_GRANT;
                end
            end
            DBAH_GR_GRANT: begin
                if (bus.dma_request_n || timeout_reg) begin
                    grant_next = DBAH_GR_RELEASE;
                end
            end
            DBAH_GR_RELEASE: begin
                if (bus.dma_request_n && as_n) begin
                    grant_next = DBAH_GR_IDLE;
                end
            end
            default: grant_next = DBAH_GR_IDLE;
        endcase
    end

    // Phase sequencer with read/wait stretch and counter clear
    always_comb begin
        wait_hold     = cpu_cycle && ds_n && (jc_reg == JC_LAST) && !timeout_reg;
        counter_clear = (jc_reg == JC_LAST) && !wait_hold;
        jc_next       = jc_reg;
        if (base_tick) begin
            if (counter_clear) begin
                jc_next = JC_START;
            end else if (!wait_hold) begin
                jc_next = dbah_jc_step(jc_reg);
            end
        end
    end
    // Johnson states 0000,1000,1100 form phase 1; the next four phase 2
    assign phase1 = ~jc_reg[1];
    assign phase2 = jc_reg[1];

    // Timeout: base ticks from address strobe until data strobe
    always_comb begin
        to_cnt_next  = to_cnt_reg;
        timeout_next = timeout_reg;
        fault_next   = fault_reg;
        if (!in_txn) begin
            to_cnt_next = '0;
        end else if (base_tick && (to_cnt_reg != TO_W'(TO_TICKS))) begin
            to_cnt_next = to_cnt_reg + 7'h1;
        end
        if (as_n) begin
            timeout_next = 1'b0;
        end else if (in_txn && base_tick && (to_cnt_reg == TO_W'(TO_TICKS))) begin
            timeout_next = 1'b1;
        end
        // Fault holds until the next transaction begins; a new timeout wins
        if (timeout_next) begin
            fault_next = 1'b1;
        end else if (!as_n && as_prev_reg) begin
            fault_next = 1'b0;
        end
    end

    // Memory and processor side capture
    always_comb begin
        mem_addr_next  = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        cpu_rdata_next = cpu_rdata_reg;
        mem_wr_next    = !as_n && !ds_n && ds_prev_reg && !bus.bus_write_n;
        if (!as_n) begin
            mem_addr_next = bus.system_address;
        end
        if (!ds_n && !bus.bus_write_n) begin
            mem_wdata_next = bus.system_data;
        end
        if (cpu_cycle && !cpu_write && !ds_n) begin
            cpu_rdata_next = bus.system_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_reg       <= '0;
            poll_half_reg <= 1'b0;
            poll_reg      <= '0;
            grant_reg     <= DBAH_GR_IDLE;
            jc_reg        <= JC_START;
            to_cnt_reg    <= '0;
            timeout_reg   <= 1'b0;
            fault_reg     <= 1'b0;
            as_prev_reg   <= 1'b1;
            ds_prev_reg   <= 1'b1;
            mem_addr_reg  <= '0;
            mem_wdata_reg <= '0;
            mem_wr_reg    <= 1'b0;
            cpu_rdata_reg <= '0;
        end else begin
            acc_reg       <= acc_next;
            poll_half_reg <= poll_half_next;
            poll_reg      <= poll_next;
            grant_reg     <= grant_next;
            jc_reg        <= jc_next;
            to_cnt_reg    <= to_cnt_next;
            timeout_reg   <= timeout_next;
            fault_reg     <= fault_next;
            as_prev_reg   <= as_n;
            ds_prev_reg   <= ds_n;
            mem_addr_reg  <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
            mem_wr_reg    <= mem_wr_next;
            cpu_rdata_reg <= cpu_rdata_next;
        end
    end

    // Bus drive on behalf of the processor and the answering memory
    assign bus.dma_grant_n           = ~(grant_reg == DBAH_GR_GRANT);
    assign bus.request_poll_count    = poll_reg;
    assign bus.transaction_timeout_n = ~timeout_reg;
    assign bus.arb_addr_oe  = cpu_own;
    assign bus.arb_addr_out = cpu_addr;
    assign bus.arb_wr_oe    = cpu_own;
    assign bus.arb_wr_out   = ~cpu_write;
    assign bus.arb_as_oe    = cpu_cycle;
    assign bus.arb_as_out   = 1'b0;
    assign bus.arb_ds_oe    = (cpu_cycle && cpu_write && cpu_data_valid) || mem_answer;
    assign bus.arb_ds_out   = 1'b0;
    assign bus.arb_data_oe  = (cpu_cycle && cpu_write) || mem_answer;
    assign bus.arb_data_out = mem_answer ? mem_rdata : cpu_wdata;

    assign cpu_data_ack      = cpu_cycle && !ds_n;
    assign cpu_rdata         = cpu_rdata_reg;
    assign mem_addr          = mem_addr_reg;
    assign mem_wdata         = mem_wdata_reg;
    assign mem_write_en      = mem_wr_reg;
    assign dma_owner         = (grant_reg == DBAH_GR_GRANT);
    assign transaction_fault = fault_reg;
endmodule

// *** logic/dbah_bus_if.sv ***
/*
 Shared system bus between the bus arbiter end and the DMA master end.
 Each party drives value and enable; the interface resolves the wires with
 pull-ups (strobes idle high, lines idle all ones).
*/
`timescale 1ns/1ns
interface dbah_bus_if;
    logic                          dma_request_n;
    logic                          dma_grant_n;
    logic [dbah_pkg::POLL_W-1:0]   request_poll_count;
    logic                          transaction_timeout_n;
    logic                          arb_as_out, arb_as_oe, mst_as_out, mst_as_oe;
    logic                          arb_ds_out, arb_ds_oe, mst_ds_out, mst_ds_oe;
    logic                          arb_wr_out, arb_wr_oe, mst_wr_out, mst_wr_oe;
    logic [dbah_pkg::ADDR_W-1:0]   arb_addr_out, mst_addr_out;
    logic                          arb_addr_oe, mst_addr_oe;
    logic [dbah_pkg::DATA_W-1:0]   arb_data_out, mst_data_out;
    logic                          arb_data_oe, mst_data_oe;
    logic                          addr_valid_strobe_n;
    logic                          data_valid_strobe_n;
    logic                          bus_write_n;
    logic [dbah_pkg::ADDR_W-1:0]   system_address;
    logic [dbah_pkg::DATA_W-1:0]   system_data;

    assign addr_valid_strobe_n = (~arb_as_oe | arb_as_out) & (~mst_as_oe | mst_as_out);
    assign data_valid_strobe_n = (~arb_ds_oe | arb_ds_out) & (~mst_ds_oe | mst_ds_out);
    assign bus_write_n         = (~arb_wr_oe | arb_wr_out) & (~mst_wr_oe | mst_wr_out);
    assign system_address = mst_addr_oe ? mst_addr_out : (arb_addr_oe ? arb_addr_out : '1);
    assign system_data    = mst_data_oe ? mst_data_out : (arb_data_oe ? arb_data_out : '1);

    modport arb (
        input  dma_request_n, addr_valid_strobe_n, data_valid_strobe_n, bus_write_n,
        input  system_address, system_data,
        output dma_grant_n, request_poll_count, transaction_timeout_n,
        output arb_as_out, arb_as_oe, arb_ds_out, arb_ds_oe, arb_wr_out, arb_wr_oe,
        output arb_addr_out, arb_addr_oe, arb_data_out, arb_data_oe
    );
    modport mst (
        input  dma_grant_n, request_poll_count, transaction_timeout_n,
        input  addr_valid_strobe_n, data_valid_strobe_n, system_data,
        output dma_request_n,
        output mst_as_out, mst_as_oe, mst_ds_out, mst_ds_oe, mst_wr_out, mst_wr_oe,
        output mst_addr_out, mst_addr_oe, mst_data_out, mst_data_oe
    );
endinterface

// *** logic/dbah_dma_master.sv ***
/*
 DMA master end: requests the shared bus at its poll level and carries out
 one character transfer per grant. Assumes the arbiter end and memory share
 the bus interface and the same clock.
*/
`timescale 1ns/1ns
module dbah_dma_master #(
    parameter logic [dbah_pkg::POLL_W-1:0] POLL_LEVEL = 3'h0
) (
    input  wire logic                        clk,          // System clock
    input  wire logic                        sys_rst,      // Sync reset, high
    dbah_bus_if.mst                          bus,          // Shared bus
    input  wire logic                        xfer_start,   // Start one transfer
    input  wire logic                        xfer_write,   // 1 = write
    input  wire logic [dbah_pkg::ADDR_W-1:0] xfer_addr,    // Target address
    input  wire logic [dbah_pkg::DATA_W-1:0] xfer_wdata,   // Write data
    output logic                             xfer_busy,    // Transfer pending
    output logic                             xfer_done,    // End pulse
    output logic [dbah_pkg::DATA_W-1:0]      xfer_rdata,   // Read data
    output logic                             xfer_error    // Last ended in timeout
);
    import dbah_pkg::*;

    dbah_mst_t           state_reg, state_next;
    logic [ADDR_W-1:0]   addr_reg, addr_next;
    logic [DATA_W-1:0]   wdata_reg, wdata_next;
    logic [DATA_W-1:0]   rdata_reg, rdata_next;
    logic                write_reg, write_next;
    logic                error_reg, error_next;
    logic                on_bus;

    assign on_bus = (state_reg == DBAH_M_ADDR) || (state_reg == DBAH_M_DATA);

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        write_next = write_reg;
        error_next = error_reg;
        case (state_reg)
            DBAH_M_IDLE: begin
                if (xfer_start) begin
                    addr_next  = xfer_addr;
                    wdata_next = xfer_wdata;
                    write_next = xfer_write;
                    state_next = DBAH_M_REQ;
                end
            end
            DBAH_M_REQ: begin
                if (!bus.dma_grant_n) begin
                    state_next = DBAH_M_ADDR;
                end
            end
            DBAH_M_ADDR: begin
                state_next = DBAH_M_DATA;
            end
            DBAH_M_DATA: begin
                if (!bus.transaction_timeout_n) begin
                    error_next = 1'b1;
                    state_next = DBAH_M_DONE;
                end else if (write_reg) begin
                    error_next = 1'b0;
                    state_next = DBAH_M_DONE;
                end else if (!bus.data_valid_strobe_n) begin
                    rdata_next = bus.system_data;
                    error_next = 1'b0;
                    state_next = DBAH_M_DONE;
                end
            end
            DBAH_M_DONE: begin
                state_next = DBAH_M_IDLE;
            end
            default: state_next = DBAH_M_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= DBAH_M_IDLE;
            addr_reg  <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            write_reg <= 1'b0;
            error_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            write_reg <= write_next;
            error_reg <= error_next;
        end
    end

    // Request only at own poll level, held through the owned transfer
    assign bus.dma_request_n = ~(((state_reg == DBAH_M_REQ)
                               && (bus.request_poll_count == POLL_LEVEL)) || on_bus);
    assign bus.mst_addr_oe  = on_bus;
    assign bus.mst_addr_out = addr_reg;
    assign bus.mst_wr_oe    = on_bus;
    assign bus.mst_wr_out   = ~write_reg;
    assign bus.mst_as_oe    = on_bus;
    assign bus.mst_as_out   = 1'b0;
    assign bus.mst_data_oe  = on_bus && write_reg;
    assign bus.mst_data_out = wdata_reg;
    // Write data is driven in ADDR, so it is valid before the strobe
    assign bus.mst_ds_oe    = (state_reg == DBAH_M_DATA) && write_reg;
    assign bus.mst_ds_out   = 1'b0;

    assign xfer_busy  = (state_reg != DBAH_M_IDLE);
    assign xfer_done  = (state_reg == DBAH_M_DONE);
    assign xfer_rdata = rdata_reg;
    assign xfer_error = error_reg;
endmodule

// *** logic/dbah_pkg.sv ***
/*
 Shared constants and types for the DMA bus arbitration and handshake pair.
 Assumes a single 100 MHz system clock; all slower rates are enable pulses.
*/
package dbah_pkg;
    localparam longint CLK_HZ   = 100_000_000;
    localparam longint BASE_HZ  = 14_745_600;
    localparam int     ACC_W    = 24;
    localparam logic [ACC_W-1:0] BASE_INC = ACC_W'((BASE_HZ << ACC_W) / CLK_HZ);
    localparam int     POLL_W   = 3;
    localparam int     ADDR_W   = 16;
    localparam int     DATA_W   = 8;
    // Transaction limit and its length in base clock ticks, rounded down
    localparam longint TIMEOUT_NS = 3800;
    localparam int     TO_TICKS   = int'((TIMEOUT_NS * BASE_HZ) / 64'd1_000_000_000);
    localparam int     TO_W       = 7;
    // Phase sequencer: 3 base ticks of phase 1 then 4 of phase 2
    localparam int     PH1_CYC  = 3;
    localparam int     PH2_CYC  = 4;
    localparam int     JC_W     = 4;
    localparam logic [JC_W-1:0] JC_START = 4'h0;
    localparam logic [JC_W-1:0] JC_LAST  = 4'h3;

    typedef enum logic [1:0] {
        DBAH_GR_IDLE    = 2'b00,
        DBAH_GR_GRANT   = 2'b01,
        DBAH_GR_RELEASE = 2'b10
    } dbah_grant_t;

    typedef enum logic [2:0] {
        DBAH_M_IDLE = 3'b000,
        DBAH_M_REQ  = 3'b001,
        DBAH_M_ADDR = 3'b010,
        DBAH_M_DATA = 3'b011,
        DBAH_M_DONE = 3'b100
    } dbah_mst_t;

    // Johnson step: shift right, inverted lsb enters at the top
    function automatic logic [JC_W-1:0] dbah_jc_step(input logic [JC_W-1:0] jc);
        dbah_jc_step = {~jc[0], jc[JC_W-1:1]};
    endfunction
endpackage

// *** tb/dbah_bus_asserts.sv ***
/*
 Checker for the shared bus between the arbiter end and the DMA master end.
 Assumes one clock domain and the resolved interface signals as inputs.
*/
`timescale 1ns/1ns
module dbah_bus_asserts (
    input wire logic                        clk,                   // Clock
    input wire logic                        sys_rst,               // Reset
    input wire logic                        dma_request_n,         // Request
    input wire logic                        dma_grant_n,           // Grant
    input wire logic [dbah_pkg::POLL_W-1:0] request_poll_count,    // Poll
    input wire logic                        transaction_timeout_n, // Timeout
    input wire logic                        addr_valid_strobe_n,   // Addr strobe
    input wire logic                        data_valid_strobe_n,   // Data strobe
    input wire logic                        bus_write_n,           // Write cycle
    input wire logic [dbah_pkg::ADDR_W-1:0] system_address,        // Address
    input wire logic [dbah_pkg::DATA_W-1:0] system_data            // Data
);
    import dbah_pkg::*;
    logic [9:0] wait_reg;

    // Cycles spent with the address strobed and no data strobe yet
    always_ff @(posedge clk) begin
        if (sys_rst || addr_valid_strobe_n || !data_valid_strobe_n) begin
            wait_reg <= 10'h0;
        end else if (wait_reg != 10'h3ff) begin
            wait_reg <= wait_reg + 10'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_grant;
        $fell(dma_grant_n);
    endsequence
    sequence s_timeout;
        $fell(transaction_timeout_n);
    endsequence

    chk_grant_cause: assert property (s_grant |->
        !$past(dma_request_n) && $past(addr_valid_strobe_n)) else $error("grant without cause");
    chk_grant_ends: assert property (s_grant |-> ##[1:420] $rose(dma_grant_n))
        else $error("grant not returned");
    chk_grant_drop: assert property ($rose(dma_request_n) |=> dma_grant_n)
        else $error("grant held after request");
    chk_grant_addr: assert property (s_grant |-> ##[1:3] !addr_valid_strobe_n)
        else $error("no address after grant");
    chk_poll_step: assert property ($changed(request_poll_count) |->
        request_poll_count == 3'($past(request_poll_count) + 3'h1)) else $error("poll skip");
    chk_poll_rate: assert property ($changed(request_poll_count) |=>
        $stable(request_poll_count)[*8]) else $error("poll too fast");
    chk_to_delay: assert property (s_timeout |->
        wait_reg >= 10'd370 && wait_reg <= 10'd400) else $error("timeout at wrong time");
    chk_to_hold: assert property (!transaction_timeout_n && !addr_valid_strobe_n |=>
        !transaction_timeout_n) else $error("timeout dropped early");
    chk_to_clear: assert property ($rose(addr_valid_strobe_n) |->
        ##[0:2] transaction_timeout_n) else $error("timeout stuck");
    chk_ds_in_as: assert property (!data_valid_strobe_n |-> !addr_valid_strobe_n)
        else $error("data strobe outside address strobe");
    chk_addr_held: assert property (!addr_valid_strobe_n && $past(!addr_valid_strobe_n) |->
        $stable(system_address)) else $error("address moved under strobe");
    chk_wdata_held: assert property (!data_valid_strobe_n && !bus_write_n &&
        $past(!data_valid_strobe_n) |-> $stable(system_data)) else $error("write data moved");
endmodule

// *** tb/tb_dma_bus_arbitration_handshake.sv ***
/*
 Testbench joining the arbiter end and the DMA master end over the bus.
 Assumes the bench plays processor and memory at the arbiter's user side.
*/
`timescale 1ns/1ns
module tb_dma_bus_arbitration_handshake;
    import dbah_pkg::*;
    logic              clk, sys_rst, cpu_addr_valid, cpu_write, cpu_data_valid, mem_en;
    logic              bus_available, mem_read_ready, cpu_data_ack, mem_write_en, phase1;
    logic              phase2, dma_owner, transaction_fault, xfer_start, xfer_write;
    logic              xfer_busy, xfer_done, xfer_error;
    logic [ADDR_W-1:0] cpu_addr, mem_addr, xfer_addr, wr_a;
    logic [DATA_W-1:0] cpu_wdata, mem_rdata, cpu_rdata, mem_wdata, xfer_wdata, xfer_rdata, wr_d;
    logic [31:0]       seed;
    int                error_cnt, n_tests, cyc, wr_n, len;

    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    dbah_bus_if u_dbah_bus_if ();
    dbah_arbiter u_dbah_arbiter (.clk(clk), .sys_rst(sys_rst), .bus(u_dbah_bus_if),
        .bus_available(bus_available), .cpu_addr(cpu_addr), .cpu_addr_valid(cpu_addr_valid),
        .cpu_write(cpu_write), .cpu_wdata(cpu_wdata), .cpu_data_valid(cpu_data_valid),
        .mem_rdata(mem_rdata), .mem_read_ready(mem_read_ready), .cpu_data_ack(cpu_data_ack),
        .cpu_rdata(cpu_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_write_en(mem_write_en), .phase1(phase1), .phase2(phase2), .dma_owner(dma_owner),
        .transaction_fault(transaction_fault));
    dbah_dma_master #(.POLL_LEVEL(3'h5)) u_dbah_dma_master (.clk(clk), .sys_rst(sys_rst),
        .bus(u_dbah_bus_if), .xfer_start(xfer_start), .xfer_write(xfer_write),
        .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_busy(xfer_busy),
        .xfer_done(xfer_done), .xfer_rdata(xfer_rdata), .xfer_error(xfer_error));
    dbah_bus_asserts u_dbah_bus_asserts (.clk(clk), .sys_rst(sys_rst),
        .dma_request_n(u_dbah_bus_if.dma_request_n), .dma_grant_n(u_dbah_bus_if.dma_grant_n),
        .request_poll_count(u_dbah_bus_if.request_poll_count),
        .transaction_timeout_n(u_dbah_bus_if.transaction_timeout_n),
        .addr_valid_strobe_n(u_dbah_bus_if.addr_valid_strobe_n),
        .data_valid_strobe_n(u_dbah_bus_if.data_valid_strobe_n),
        .bus_write_n(u_dbah_bus_if.bus_write_n), .system_address(u_dbah_bus_if.system_address),
        .system_data(u_dbah_bus_if.system_data));

    assign bus_available  = phase1 & ~cpu_addr_valid;
    assign mem_read_ready = mem_en;
    assign mem_rdata      = exp_rd(u_dbah_bus_if.system_address);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("Comparisons: %0d  mismatches: %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            error_cnt++;
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mem_write_en === 1'b1) begin
            wr_a <= mem_addr;
            wr_d <= mem_wdata;
            wr_n <= wr_n + 1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    // One DMA character; to = no memory answer
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input logic to);
        int   n;
        int   c;
        logic own;
        n = 0;
        c = wr_n;
        own = 1'b0;
        mem_en = ~to;
        xfer_write = w;
        xfer_addr = a;
        xfer_wdata = d;
        xfer_start = 1'b1;
        tick();
        xfer_start = 1'b0;
        check(16'(xfer_busy), 16'h1);
        while (xfer_done !== 1'b1 && n < 2000) begin
            if (dma_owner === 1'b1) own = 1'b1;
            tick();
            n++;
        end
        check(16'(own), 16'h1);
        check(16'(xfer_error), 16'(to));
        check(16'(transaction_fault), 16'(to));
        if (!w && !to) check(16'(xfer_rdata), 16'(exp_rd(a)));
        tick();
        tick();
        check(16'(wr_n - c), 16'(w & ~to));
        if (w) check(wr_a, a);
        if (w) check(16'(wr_d), 16'(d));
        mem_en = 1'b1;
    endtask

    task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        int c;
        n = 0;
        c = wr_n;
        cpu_write = w;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_addr_valid = 1'b1;
        cpu_data_valid = w;
        while (cpu_data_ack !== 1'b1 && n < 1000) begin
            tick();
            n++;
        end
        // Two strobed edges so held address and write data are watched
        repeat (2) tick();
        cpu_addr_valid = 1'b0;
        cpu_data_valid = 1'b0;
        tick();
        tick();
        if (w) check(wr_a, a);
        else check(16'(cpu_rdata), 16'(exp_rd(a)));
        check(16'(wr_n - c), 16'(w));
    endtask

    task automatic phase_len(input logic p2, input int lo, input int hi);
        len = 0;
        while ((p2 ? phase2 : phase1) !== 1'b1) tick();
        while ((p2 ? phase2 : phase1) === 1'b1) begin
            tick();
            len++;
        end
        check(16'(len >= lo && len <= hi), 16'h1);
    endtask

    initial begin
        {cpu_addr_valid, cpu_write, cpu_data_valid, xfer_start, xfer_write} = '0;
        {cpu_addr, cpu_wdata, xfer_addr, xfer_wdata} = '0;
        seed = 32'h45fd;
        {error_cnt, n_tests, cyc, wr_n} = '0;
        mem_en = 1'b1;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
        phase_len(1'b0, 19, 22);
        phase_len(1'b1, 26, 29);
        xfer(1'b1, 16'h0000, 8'h00, 1'b0);
        xfer(1'b0, 16'hffff, 8'h00, 1'b0);
        xfer(1'b0, 16'h1234, 8'h00, 1'b1);
        xfer(1'b1, 16'hffff, 8'hff, 1'b0);
        cpu(1'b1, 16'h0a55, 8'h3c);
        cpu(1'b0, 16'h8001, 8'h00);
        // Processor read that memory never answers: timeout must free the phases
        mem_en = 1'b0;
        cpu_write = 1'b0;
        cpu_addr = 16'h4321;
        cpu_addr_valid = 1'b1;
        repeat (450) tick();
        check(16'(transaction_fault), 16'h1);
        while (phase1 === 1'b1) tick();
        phase_len(1'b0, 19, 22);
        cpu_addr_valid = 1'b0;
        mem_en = 1'b1;
        tick();
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            if (seed[3:2] == 2'h0) cpu(seed[0], seed[31:16], seed[15:8]);
            else xfer(seed[0], seed[31:16], seed[15:8], 1'b0);
        end
        sys_rst = 1'b1;
        tick();
        tick();
        check(16'(u_dbah_bus_if.request_poll_count), 16'h0);
        sys_rst = 1'b0;
        xfer(1'b0, 16'h00ff, 8'h00, 1'b0);
        conclude();
    end
endmodule
